// ### inc/crr_pkg.sv
// Purpose: Shared constants and carriers for the carry/return/rotate executor
// Assumes: 8-bit data, 8-bit stack pointer, 16-bit program counter
// Notes: Cycle counts are core clock cycles per instruction
package crr_pkg;
    localparam logic [7:0] OPC_CLEAR_CARRY = 8'hcf;
    localparam logic [7:0] OPC_RETURN = 8'haf;
    localparam logic [7:0] OPC_ROTATE_REG = 8'h90;
    localparam logic [7:0] OPC_ROTATE_PTR = 8'h91;
    localparam logic [3:0] CYC_CLEAR_CARRY = 4'h4;
    localparam logic [3:0] CYC_RETURN = 4'h8;
    localparam logic [3:0] CYC_ROTATE = 4'h4;
    localparam logic [7:0] SP_RETURN_STEP = 8'h02;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_CLEAR_CARRY,
        OP_RETURN,
        OP_ROTATE
    } op_e;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] flags;
    } rot_out_s;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] operand;
    } instr_s;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_s;
endpackage

// ### src/rotate_left_unit.sv
// Purpose: Combinational rotate-left with flag update
// Assumes: Flags laid out as in the package
// Notes: Pure logic, the caller registers the outputs
`timescale 1ns/1ps
`default_nettype none
module rotate_left_unit
    import crr_pkg::*;
(
    input wire logic [7:0] operand_i,
    input wire logic [7:0] flags_i,
    output crr_pkg::rot_out_s out_o
);
    logic [7:0] res;
    always_comb begin
        res = {operand_i[6:0], operand_i[7]};
        out_o.result = res;
        out_o.flags = flags_i;
        out_o.flags[FLAG_C] = operand_i[7];
        out_o.flags[FLAG_Z] = (res == 8'h00);
        out_o.flags[FLAG_S] = res[7];
        out_o.flags[FLAG_V] = res[7] ^ operand_i[7];
    end
endmodule
`default_nettype wire

// ### src/carry_return_rotate_exec.sv
// Purpose: Executes clear-carry, subroutine return and rotate-left
// Assumes: Register file and stack memory reads answer combinationally
// Notes: One instruction at a time; BUSY_O holds until the cycle count ends
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Clear-carry forces carry flag to zero.
// - Clear-carry keeps every other flag unchanged.
// - Return loads program counter from stack at stack pointer.
// - High byte at stack pointer, low byte next; pointer plus two.
// - After return, next fetch uses the new program counter.
// - Return changes no flag.
// - Rotate-left moves bit n to bit n+1 for n 0..6.
// - Old bit 7 goes to result bit 0 and carry.
// - Carry set when old bit 7 was one, else cleared.
// - Zero flag set when rotated result is zero.
// - Sign flag equals result bit 7.
// - Overflow set when sign bit changed by the rotation.
module carry_return_rotate_exec
    import crr_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire crr_pkg::instr_s INSTR_I,
    input wire logic [7:0] REG_RDATA_I,
    input wire logic [7:0] STACK_RDATA_I,
    input wire logic [7:0] FLAGS_I,
    input wire logic FLAGS_LOAD_I,
    output logic [7:0] REG_RADDR_O,
    output logic [7:0] STACK_RADDR_O,
    output crr_pkg::reg_wr_s REG_WR_O,
    output logic [7:0] FLAGS_O,
    output logic [7:0] SP_O,
    output logic [15:0] PC_O,
    output logic PC_LOAD_O,
    output logic BUSY_O,
    output logic DONE_O
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PTR,
        ST_OPER,
        ST_POP_HI,
        ST_POP_LO,
        ST_WAIT
    } state_e;

    typedef struct packed {
        state_e st;
        op_e op;
        logic [3:0] cnt;
        logic [7:0] dst;
        logic [7:0] raddr;
        logic [7:0] saddr;
        logic [7:0] pc_hi;
        reg_wr_s wr;
        logic [7:0] flags;
        logic [7:0] sp;
        logic [15:0] pc;
        logic pc_load;
        logic busy;
        logic done;
    } exec_s;

    exec_s s_q, s_d;
    rot_out_s rot;

    rotate_left_unit u_rot (
        .operand_i(REG_RDATA_I),
        .flags_i(s_q.flags),
        .out_o(rot)
    );

    always_comb begin
        s_d = s_q;
        s_d.wr.we = 1'b0;
        s_d.pc_load = 1'b0;
        s_d.done = 1'b0;
        if (FLAGS_LOAD_I && !s_q.busy) begin
            s_d.flags = FLAGS_I;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (INSTR_I.valid) begin
                    s_d.busy = 1'b1;
                    s_d.dst = INSTR_I.operand;
                    s_d.raddr = INSTR_I.operand;
                    case (INSTR_I.opcode)
                        OPC_CLEAR_CARRY: begin
                            s_d.op = OP_CLEAR_CARRY;
                            s_d.flags[FLAG_C] = 1'b0;
                            // Count runs from the taking edge to the done pulse
                            s_d.cnt = CYC_CLEAR_CARRY - 4'h1;
                            s_d.st = ST_WAIT;
                        end
                        OPC_RETURN: begin
                            s_d.op = OP_RETURN;
                            s_d.saddr = s_q.sp;
                            s_d.st = ST_POP_HI;
                        end
                        OPC_ROTATE_REG: begin
                            s_d.op = OP_ROTATE;
                            s_d.cnt = CYC_ROTATE - 4'h2;
                            s_d.st = ST_OPER;
                        end
                        OPC_ROTATE_PTR: begin
                            s_d.op = OP_ROTATE;
                            // Pointer fetch costs one cycle of the budget
                            s_d.cnt = CYC_ROTATE - 4'h3;
                            s_d.st = ST_PTR;
                        end
                        default: begin
                            // Foreign opcodes belong to other units
                            s_d.busy = 1'b0;
                            s_d.op = OP_NONE;
                        end
                    endcase
                end
            end
            ST_PTR: begin
                s_d.dst = REG_RDATA_I;
                s_d.raddr = REG_RDATA_I;
                s_d.st = ST_OPER;
            end
            ST_OPER: begin
                s_d.wr.we = 1'b1;
                s_d.wr.addr = s_q.dst;
                s_d.wr.data = rot.result;
                s_d.flags = rot.flags;
                // Remaining count was preloaded at decode
                s_d.st = ST_WAIT;
            end
            ST_POP_HI: begin
                s_d.pc_hi = STACK_RDATA_I;
                s_d.saddr = s_q.sp + 8'h01;
                s_d.st = ST_POP_LO;
            end
            ST_POP_LO: begin
                // Flags untouched on this path
                s_d.pc = {s_q.pc_hi, STACK_RDATA_I};
                s_d.pc_load = 1'b1;
                s_d.sp = s_q.sp + SP_RETURN_STEP;
                s_d.cnt = CYC_RETURN - 4'h3;
                s_d.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (s_q.cnt <= 4'h1) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s_q <= '{st: ST_IDLE, op: OP_NONE, cnt: 4'h0, dst: 8'h00, raddr: 8'h00,
                saddr: 8'h00, pc_hi: 8'h00, wr: '0, flags: FLAGS_RESET, sp: SP_RESET,
                pc: PC_RESET, pc_load: 1'b0, busy: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        REG_RADDR_O = s_q.raddr;
        STACK_RADDR_O = s_q.saddr;
        REG_WR_O = s_q.wr;
        FLAGS_O = s_q.flags;
        SP_O = s_q.sp;
        PC_O = s_q.pc;
        PC_LOAD_O = s_q.pc_load;
        BUSY_O = s_q.busy;
        DONE_O = s_q.done;
    end

    // Instruction length in cycles, counted from acceptance
    logic [3:0] len_q;
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            len_q <= 4'h0;
        end else if (!s_q.busy) begin
            len_q <= 4'h1;
        end else begin
            len_q <= len_q + 4'h1;
        end
    end

    a_clear_carry_zero: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_IDLE && INSTR_I.valid && INSTR_I.opcode == OPC_CLEAR_CARRY
        |=> !FLAGS_O[FLAG_C]) else $error("carry not cleared");
    a_clear_carry_keep: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_IDLE && INSTR_I.valid && INSTR_I.opcode == OPC_CLEAR_CARRY && !FLAGS_LOAD_I
        |=> FLAGS_O[6:0] == $past(FLAGS_O[6:0])) else $error("clear carry changed flags");
    a_return_addr: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_POP_HI |-> STACK_RADDR_O == SP_O) else $error("return reads wrong slot");
    a_return_pc: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_POP_LO |=> PC_O == {$past(s_q.pc_hi), $past(STACK_RDATA_I)}
        && SP_O == $past(SP_O) + 8'h02) else $error("return pc or sp wrong");
    a_return_load: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_POP_LO |=> PC_LOAD_O ##1 !PC_LOAD_O) else $error("pc load pulse wrong");
    a_return_flags: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.op == OP_RETURN && s_q.busy |=> $stable(FLAGS_O)) else $error("return touched flags");
    a_rotate_data: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_OPER |=> REG_WR_O.we
        && REG_WR_O.data == {$past(REG_RDATA_I[6:0]), $past(REG_RDATA_I[7])})
        else $error("rotate result wrong");
    a_rotate_carry: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_OPER |=> FLAGS_O[FLAG_C] == $past(REG_RDATA_I[7])) else $error("carry wrong");
    a_rotate_zs: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_OPER |=> FLAGS_O[FLAG_Z] == (REG_WR_O.data == 8'h00)
        && FLAGS_O[FLAG_S] == REG_WR_O.data[7]) else $error("zero or sign wrong");
    a_rotate_ovf: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        s_q.st == ST_OPER |=> FLAGS_O[FLAG_V] == (REG_WR_O.data[7] != $past(REG_RDATA_I[7])))
        else $error("overflow wrong");
    a_cycle_count: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        DONE_O && s_q.op == OP_RETURN |-> len_q == CYC_RETURN) else $error("return length wrong");
    a_clear_length: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        DONE_O && s_q.op == OP_CLEAR_CARRY |-> len_q == CYC_CLEAR_CARRY)
        else $error("clear length wrong");
    a_rotate_length: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
        DONE_O && s_q.op == OP_ROTATE |-> len_q == CYC_ROTATE) else $error("rotate length wrong");
    c_clear: cover property (@(posedge REF_CLK_I) DONE_O && s_q.op == OP_CLEAR_CARRY);
    c_return: cover property (@(posedge REF_CLK_I) DONE_O && s_q.op == OP_RETURN);
    c_rot_ptr: cover property (@(posedge REF_CLK_I) s_q.st == ST_PTR ##1 s_q.st == ST_OPER);
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the carry/return/rotate executor
// Assumes: Register file and stack memory modelled here, read combinationally
// Notes: Inputs change on the falling edge; flags preloaded through the load port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    instr_s instr = '0;
    logic [7:0] flags_in = 8'h00;
    logic flags_ld = 1'b0;
    logic [7:0] regs [256];
    logic [7:0] stk [256];
    logic [7:0] raddr, saddr, flags, sp;
    logic [15:0] pc;
    logic pc_ld, busy, done;
    reg_wr_s wr;
    reg_wr_s last_wr;
    int pc_ld_n, n, n_errors = 0, compares = 0;

    always #50 clk = ~clk;

    // Register file write port and pulse counting
    always @(posedge clk) begin
        if (wr.we === 1'b1) begin
            regs[wr.addr] <= wr.data;
            last_wr <= wr;
        end
        if (pc_ld === 1'b1) pc_ld_n <= pc_ld_n + 1;
    end

    carry_return_rotate_exec dut (
        .REF_CLK_I(clk), .RSTN_I(rstn), .INSTR_I(instr),
        .REG_RDATA_I(regs[raddr]), .STACK_RDATA_I(stk[saddr]),
        .FLAGS_I(flags_in), .FLAGS_LOAD_I(flags_ld),
        .REG_RADDR_O(raddr), .STACK_RADDR_O(saddr), .REG_WR_O(wr),
        .FLAGS_O(flags), .SP_O(sp), .PC_O(pc), .PC_LOAD_O(pc_ld),
        .BUSY_O(busy), .DONE_O(done)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("FAIL t=%0t %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic load_flags(input logic [7:0] f);
        @(negedge clk);
        flags_in = f;
        flags_ld = 1'b1;
        @(negedge clk);
        flags_ld = 1'b0;
    endtask

    // Bounded wait, so a missing completion cannot hang the run
    task automatic run(input logic [7:0] opc, input logic [7:0] opd);
        @(negedge clk);
        instr = '{1'b1, opc, opd};
        pc_ld_n = 0;
        last_wr = '0;
        @(negedge clk);
        instr.valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_clear;
        load_flags(8'hff);
        run(OPC_CLEAR_CARRY, 8'h00);
        chk_cyc(n, 4, 4, "clear cycles");
        chk(flags, 8'h7f, "clear from set");
        load_flags(8'h00);
        run(OPC_CLEAR_CARRY, 8'h00);
        chk(flags, 8'h00, "clear from clear");
        $display("test clear carry done");
    endtask

    task automatic t_return;
        stk[0] = 8'h10; stk[1] = 8'h1a; stk[2] = 8'hab; stk[3] = 8'hcd;
        load_flags(8'ha5);
        run(OPC_RETURN, 8'h00);
        chk_cyc(n, 8, 8, "return cycles");
        chk(pc, 16'h101a, "return pc");
        chk(sp, 8'h02, "return sp");
        chk(16'(pc_ld_n), 16'h0001, "pc load pulses");
        chk(flags, 8'ha5, "return flags");
        run(OPC_RETURN, 8'h00);
        chk(pc, 16'habcd, "second return pc");
        chk(sp, 8'h04, "second return sp");
        $display("test return done");
    endtask

    // Requests while busy must be dropped, flags untouched by the return
    task automatic t_refuse;
        stk[4] = 8'h12; stk[5] = 8'h34;
        load_flags(8'h80);
        @(negedge clk);
        instr = '{1'b1, OPC_RETURN, 8'h00};
        @(negedge clk);
        instr = '{1'b1, OPC_CLEAR_CARRY, 8'h00};
        flags_in = 8'h00;
        flags_ld = 1'b1;
        @(negedge clk);
        instr.valid = 1'b0;
        flags_ld = 1'b0;
        n = 2;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(flags, 8'h80, "busy refusal flags");
        chk(pc, 16'h1234, "busy return pc");
        chk(sp, 8'h06, "busy return sp");
        chk(busy, 1'b0, "idle after return");
        $display("test refusal done");
    endtask

    task automatic t_rotate;
        logic [7:0] opc [5] = '{8'h90, 8'h90, 8'h91, 8'h90, 8'h90};
        logic [7:0] opd [5] = '{8'h00, 8'h05, 8'h01, 8'h06, 8'h07};
        logic [7:0] val [5] = '{8'haa, 8'h00, 8'h17, 8'h40, 8'h81};
        logic [7:0] dst, res, fl;
        for (int i = 0; i < 5; i++) begin
            regs[opd[i]] = val[i];
            if (opc[i] == OPC_ROTATE_PTR) begin
                regs[opd[i]] = 8'h02;
                regs[8'h02] = val[i];
            end
            dst = regs[opd[i]];
            if (opc[i] == OPC_ROTATE_REG) dst = opd[i];
            fl = (i % 2) ? 8'hf3 : 8'h0c;
            load_flags(fl);
            res = {val[i][6:0], val[i][7]};
            run(opc[i], opd[i]);
            chk_cyc(n, 4, 4, "rotate cycles");
            chk(last_wr.addr, dst, "rotate dest");
            chk(last_wr.data, res, "rotate result");
            chk(regs[dst], res, "rotate stored");
            chk(flags[7:4], {val[i][7], res == 8'h00, res[7], val[i][7] ^ res[7]},
                "rotate c z s v");
            chk(flags[3:0], fl[3:0], "rotate d h");
        end
        $display("test rotate done");
    endtask

    task automatic t_unknown;
        @(negedge clk);
        instr = '{1'b1, 8'h10, 8'h00};
        @(negedge clk);
        instr.valid = 1'b0;
        chk(busy, 1'b0, "unknown opcode ignored");
        $display("test unknown opcode done");
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole sequence is under a hundred cycles; allow a wide margin
    initial begin
        #(100 * 3000);
        n_errors++;
        results;
    end

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        chk(flags, FLAGS_RESET, "reset flags");
        chk(sp, SP_RESET, "reset sp");
        chk(pc, PC_RESET, "reset pc");
        t_clear;
        t_return;
        t_refuse;
        t_rotate;
        t_unknown;
        results;
    end
endmodule
`default_nettype wire
